// ---- core/vr_serial_register_status_map.vh ----
// register indices, field positions, reset values and thresholds for the
// regulator's upper register file and primary status register.
// assumes a decoded command port driven by the serial bus frame logic.
`ifndef VR_SERIAL_REGISTER_STATUS_MAP_VH
`define VR_SERIAL_REGISTER_STATUS_MAP_VH

`define IDX_PRIMARY_STATUS      8'h10
`define IDX_MAX_OUTPUT_CODE     8'h30
`define IDX_OUTPUT_CODE_SETTING 8'h31
`define IDX_POWER_STATE         8'h32
`define IDX_OUTPUT_CODE_OFFSET  8'h33
`define IDX_MULTI_REG_CONFIG    8'h34
`define IDX_INDIRECT_SCRATCH    8'h35

`define RST_MAX_OUTPUT_CODE     8'hfb
`define RST_ZERO                8'h00

`define BIT_SETTLED             0
`define BIT_THERMAL             1
`define BIT_OVERCURRENT         2
`define BIT_SEC_CHANGED         7

// fixed thermal reference in binary degrees (+100 C)
`define MAX_TEMPERATURE         8'h64
// alert threshold percentage of the reference
`define THERMAL_ALERT_PCT       8'h61

// command codes on the decoded command port
`define CMD_SET_OUTPUT_CODE     3'h1
`define CMD_READ_REGISTER       3'h2
`define CMD_WRITE_REGISTER      3'h3
`define CMD_SET_INDEX           3'h4
`define CMD_WRITE_INDEXED       3'h5

// acknowledge codes
`define ACK_OK                  2'h1
`define ACK_NOT_SUPPORTED       2'h2
`define ACK_REJECT              2'h3

`endif

// ---- core/vr_serial_register_status.v ----
// upper register file (indices 30h-35h) and primary status register (10h)
// of a voltage regulator's serial output-code interface.
// assumes frame decode and parity are handled outside; one command per
// cmd_valid_in pulse, answered on the next clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "vr_serial_register_status_map.vh"

module vr_serial_register_status #(
    parameter CODE_W = 8                          // register and code width
) (
    input  wire              clk_sys_in,          // system clock, 250 MHz
    input  wire              rst_in,              // synchronous reset, high
    input  wire              cmd_valid_in,        // command strobe, one cycle
    input  wire [2:0]        cmd_code_in,         // decoded command
    input  wire [7:0]        cmd_index_in,        // register index
    input  wire [CODE_W-1:0] cmd_data_in,         // command payload
    input  wire              output_in_window_in, // output within 10mV of target
    input  wire [7:0]        temp_zone_in,        // measured temperature zone bits
    input  wire              overcurrent_in,      // live overcurrent condition
    input  wire              secondary_status_changed_in, // secondary status nonzero
    input  wire              modulator_ps_wr_in,  // modulator writes power state
    input  wire [CODE_W-1:0] modulator_ps_in,     // power state from modulator
    output reg               ack_valid_out,       // answer strobe, one cycle
    output reg  [1:0]        ack_code_out,        // answer code
    output reg  [CODE_W-1:0] rd_data_out,         // read data
    output reg  [CODE_W-1:0] output_code_target_out, // offset-adjusted code
    output reg  [CODE_W-1:0] multi_reg_config_out,   // configuration bits
    output reg  [CODE_W-1:0] power_state_out,     // programmed power state
    output reg               alert_n_out          // alert toward master, active low
);

    reg  [CODE_W-1:0] max_code_r;
    reg  [CODE_W-1:0] code_setting_r;
    reg  [CODE_W-1:0] offset_r;
    reg  [7:0]        scratch_r;
    reg               settle_pending_r;
    reg               settled_r;
    reg               oc_latched_r;
    reg  [7:0]        status_seen_r;
    reg  [7:0]        status_now;
    reg  [7:0]        rd_mux;
    reg               rd_hit;
    reg               wr_en;
    reg  [7:0]        wr_index;
    wire              thermal_now;
    wire              status_read;
    wire              code_req;
    wire [CODE_W:0]   code_sum;
    wire              rd_cmd;
    wire              code_accept;
    wire              set_index;
    wire [7:0]        status_diff;
    reg               wr_hit;

    reg  [CODE_W-1:0] max_code_nxt;
    reg  [CODE_W-1:0] code_setting_nxt;
    reg  [CODE_W-1:0] power_state_nxt;
    reg  [CODE_W-1:0] offset_nxt;
    reg  [CODE_W-1:0] config_nxt;
    reg  [7:0]        scratch_nxt;
    reg               settle_pending_nxt;
    reg               settled_nxt;
    reg               oc_latched_nxt;
    reg  [7:0]        status_seen_nxt;
    reg  [1:0]        ack_code_nxt;
    reg  [CODE_W-1:0] rd_data_nxt;
    reg               alert_n_nxt;
    genvar            gi;

    // zone bit 6 is the 97 percent comparator trip against the reference
    assign thermal_now = temp_zone_in[6];
    assign status_read = cmd_valid_in && cmd_code_in == `CMD_READ_REGISTER
                         && cmd_index_in == `IDX_PRIMARY_STATUS;
    assign code_req    = cmd_valid_in && cmd_code_in == `CMD_SET_OUTPUT_CODE;
    // offset sign-extended; wrap is left to the caller's range check
    assign code_sum    = {1'b0, code_setting_r} + {offset_r[CODE_W-1], offset_r};
    assign rd_cmd      = cmd_valid_in && cmd_code_in == `CMD_READ_REGISTER;
    // a code equal to the limit is still accepted; only codes above it are refused
    assign code_accept = code_req && cmd_data_in <= max_code_r;
    assign set_index   = cmd_valid_in && cmd_code_in == `CMD_SET_INDEX;

    always @* begin
        status_now = 8'h00;
        status_now[`BIT_SETTLED]     = settled_r;
        status_now[`BIT_THERMAL]     = thermal_now;
        status_now[`BIT_OVERCURRENT] = oc_latched_r;
        status_now[`BIT_SEC_CHANGED] = secondary_status_changed_in;
    end

    always @* begin
        wr_en    = 1'b0;
        wr_index = cmd_index_in;
        if (cmd_valid_in && cmd_code_in == `CMD_WRITE_REGISTER) begin
            wr_en = 1'b1;
        end else if (cmd_valid_in && cmd_code_in == `CMD_WRITE_INDEXED) begin
            wr_en    = 1'b1;
            wr_index = scratch_r;
        end
    end

    always @* begin
        rd_hit = 1'b1;
        case (cmd_index_in)
            `IDX_PRIMARY_STATUS:      rd_mux = status_now;
            `IDX_MAX_OUTPUT_CODE:     rd_mux = max_code_r;
            `IDX_OUTPUT_CODE_SETTING: rd_mux = code_setting_r;
            `IDX_POWER_STATE:         rd_mux = power_state_out;
            `IDX_OUTPUT_CODE_OFFSET:  rd_mux = offset_r;
            `IDX_MULTI_REG_CONFIG:    rd_mux = multi_reg_config_out;
            `IDX_INDIRECT_SCRATCH:    rd_mux = scratch_r;
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // one change detector per status bit; reserved bits compare zero to zero
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_status_diff
            assign status_diff[gi] = status_now[gi] ^ status_seen_r[gi];
        end
    endgenerate

    // only the six indices of this block take writes; everything else refuses
    always @* begin
        case (wr_index)
            `IDX_MAX_OUTPUT_CODE,
            `IDX_OUTPUT_CODE_SETTING,
            `IDX_POWER_STATE,
            `IDX_OUTPUT_CODE_OFFSET,
            `IDX_MULTI_REG_CONFIG,
            `IDX_INDIRECT_SCRATCH: wr_hit = 1'b1;
            default:               wr_hit = 1'b0;
        endcase
    end

    // the limit only ever moves on a master write
    always @* begin
        max_code_nxt = max_code_r;
        if (wr_en && wr_index == `IDX_MAX_OUTPUT_CODE) begin
            max_code_nxt = cmd_data_in;
        end
    end

    always @* begin
        code_setting_nxt = code_setting_r;
        if (code_accept) begin
            code_setting_nxt = cmd_data_in;
        end else if (wr_en && wr_index == `IDX_OUTPUT_CODE_SETTING) begin
            code_setting_nxt = cmd_data_in;
        end
    end

    // a master write beats a modulator write landing in the same cycle
    always @* begin
        power_state_nxt = power_state_out;
        if (wr_en && wr_index == `IDX_POWER_STATE) begin
            power_state_nxt = cmd_data_in;
        end else if (modulator_ps_wr_in) begin
            power_state_nxt = modulator_ps_in;
        end
    end

    always @* begin
        offset_nxt = offset_r;
        if (wr_en && wr_index == `IDX_OUTPUT_CODE_OFFSET) begin
            offset_nxt = cmd_data_in;
        end
    end

    always @* begin
        config_nxt = multi_reg_config_out;
        if (wr_en && wr_index == `IDX_MULTI_REG_CONFIG) begin
            config_nxt = cmd_data_in;
        end
    end

    // the set-index command and a plain write to the scratch index both load it
    always @* begin
        scratch_nxt = scratch_r;
        if (set_index) begin
            scratch_nxt = cmd_data_in;
        end else if (wr_en && wr_index == `IDX_INDIRECT_SCRATCH) begin
            scratch_nxt = cmd_data_in;
        end
    end

    // settled falls on every accepted code and rises only once the output has
    // come into the window; no timer here, the window input is trusted as is
    always @* begin
        settle_pending_nxt = settle_pending_r;
        settled_nxt        = settled_r;
        if (code_accept) begin
            settle_pending_nxt = 1'b1;
            settled_nxt        = 1'b0;
        end else if (!output_in_window_in) begin
            settled_nxt = 1'b0;
        end else if (settle_pending_r) begin
            settle_pending_nxt = 1'b0;
            settled_nxt        = 1'b1;
        end
    end

    // a live condition wins over the refresh of a status read in one cycle
    always @* begin
        oc_latched_nxt = oc_latched_r;
        if (overcurrent_in) begin
            oc_latched_nxt = 1'b1;
        end else if (status_read) begin
            oc_latched_nxt = 1'b0;
        end
    end

    // one command per cycle, so the refusal causes below never meet
    always @* begin
        ack_code_nxt = `ACK_OK;
        if (code_req && !code_accept) begin
            ack_code_nxt = `ACK_NOT_SUPPORTED;
        end else if (wr_en && !wr_hit) begin
            ack_code_nxt = `ACK_REJECT;
        end else if (rd_cmd && !rd_hit) begin
            ack_code_nxt = `ACK_REJECT;
        end
    end

    // read data holds between reads so the master may pick it up late
    always @* begin
        rd_data_nxt = rd_data_out;
        if (rd_cmd) begin
            rd_data_nxt = rd_mux;
        end
    end

    // the alert holds until a status read; a window or overcurrent input change in the read cycle
    // shows up one cycle later, while thermal and secondary changes there are captured with no alert
    always @* begin
        status_seen_nxt = status_seen_r;
        alert_n_nxt     = alert_n_out;
        if (status_read) begin
            status_seen_nxt = status_now;
            alert_n_nxt     = 1'b1;
        end else if (|status_diff) begin
            alert_n_nxt = 1'b0;
        end
    end

    // all state moves here; the blocks above only compute next values
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            max_code_r             <= `RST_MAX_OUTPUT_CODE;
            code_setting_r         <= `RST_ZERO;
            power_state_out        <= `RST_ZERO;
            offset_r               <= `RST_ZERO;
            multi_reg_config_out   <= `RST_ZERO;
            scratch_r              <= `RST_ZERO;
            settle_pending_r       <= 1'b0;
            settled_r              <= 1'b0;
            oc_latched_r           <= 1'b0;
            status_seen_r          <= 8'h00;
            ack_valid_out          <= 1'b0;
            ack_code_out           <= 2'h0;
            rd_data_out            <= 8'h00;
            output_code_target_out <= 8'h00;
            alert_n_out            <= 1'b1;
        end else begin
            max_code_r             <= max_code_nxt;
            code_setting_r         <= code_setting_nxt;
            power_state_out        <= power_state_nxt;
            offset_r               <= offset_nxt;
            multi_reg_config_out   <= config_nxt;
            scratch_r              <= scratch_nxt;
            settle_pending_r       <= settle_pending_nxt;
            settled_r              <= settled_nxt;
            oc_latched_r           <= oc_latched_nxt;
            status_seen_r          <= status_seen_nxt;
            ack_valid_out          <= cmd_valid_in;
            ack_code_out           <= ack_code_nxt;
            rd_data_out            <= rd_data_nxt;
            output_code_target_out <= code_sum[CODE_W-1:0];
            alert_n_out            <= alert_n_nxt;
        end
    end

endmodule
`default_nettype wire

// ---- sim/vr_status_checker.sv ----
// assertions on the register file and primary status register ports
// assumes it is bound onto the register file top module
`timescale 1ns/1ps
`default_nettype none
`include "vr_serial_register_status_map.vh"
module vr_status_checker #(parameter CODE_W = 8) (
    input wire logic              clk_sys_in, rst_in, cmd_valid_in,
    input wire logic [2:0]        cmd_code_in,
    input wire logic [7:0]        cmd_index_in, temp_zone_in,
    input wire logic [CODE_W-1:0] cmd_data_in, modulator_ps_in,
    input wire logic              output_in_window_in, overcurrent_in,
    input wire logic              secondary_status_changed_in, modulator_ps_wr_in,
    input wire logic              ack_valid_out, alert_n_out,
    input wire logic [1:0]        ack_code_out,
    input wire logic [CODE_W-1:0] rd_data_out, output_code_target_out,
    input wire logic [CODE_W-1:0] multi_reg_config_out, power_state_out
);
    logic [7:0] max_r;
    logic [7:0] scr_r;
    wire wr_c = cmd_valid_in && cmd_code_in == `CMD_WRITE_REGISTER;
    wire wr_i = cmd_valid_in && cmd_code_in == `CMD_WRITE_INDEXED;
    wire rd_c = cmd_valid_in && cmd_code_in == `CMD_READ_REGISTER;
    wire rd_st = rd_c && cmd_index_in == `IDX_PRIMARY_STATUS;
    wire bad = rd_c && !rd_st && (cmd_index_in < 8'h30 || cmd_index_in > 8'h35);
    wire hi = cmd_valid_in && cmd_code_in == `CMD_SET_OUTPUT_CODE && cmd_data_in > max_r;
    // shadow of the limit and the index pointer, so refusals can be predicted
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            max_r <= `RST_MAX_OUTPUT_CODE;
            scr_r <= `RST_ZERO;
        end else begin
            if ((wr_c && cmd_index_in == 8'h30) || (wr_i && scr_r == 8'h30))
                max_r <= cmd_data_in[7:0];
            if ((wr_c && cmd_index_in == 8'h35) || (wr_i && scr_r == 8'h35)
                || (cmd_valid_in && cmd_code_in == `CMD_SET_INDEX))
                scr_r <= cmd_data_in[7:0];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    a_ack_follows: assert property (cmd_valid_in |=> ack_valid_out) else $error("no answer");
    a_no_stray_ack: assert property (!cmd_valid_in |=> !ack_valid_out) else $error("stray answer");
    a_above_max: assert property (hi |=> ack_code_out == `ACK_NOT_SUPPORTED
        ##1 $stable(output_code_target_out)) else $error("high code accepted");
    a_unmapped_read: assert property (bad |=> ack_code_out == `ACK_REJECT
        && rd_data_out == 8'h00) else $error("unmapped read answered");
    a_reserved_zero: assert property (rd_st |=> rd_data_out[6:3] == 4'h0) else $error("reserved set");
    a_thermal_bit: assert property (rd_st && $stable(temp_zone_in[6])
        |=> rd_data_out[1] == $past(temp_zone_in[6])) else $error("thermal bit wrong");
    a_not_settled: assert property (rd_st && !output_in_window_in && !$past(output_in_window_in)
        |=> !rd_data_out[0]) else $error("settled while slewing");
    a_target_quiet: assert property (!$past(cmd_valid_in) && !$past(cmd_valid_in, 2)
        |-> $stable(output_code_target_out)) else $error("target moved");
    a_modulator_ps: assert property (modulator_ps_wr_in && !(wr_c && cmd_index_in == 8'h32)
        && !(wr_i && scr_r == 8'h32) |=> power_state_out == $past(modulator_ps_in))
        else $error("modulator write lost");
    a_config_write: assert property (wr_c && cmd_index_in == 8'h34
        |=> multi_reg_config_out == $past(cmd_data_in)) else $error("config not written");
    a_thermal_alert: assert property ($rose(temp_zone_in[6]) && !rd_st
        |-> ##[1:3] !alert_n_out) else $error("no alert");
endmodule
bind vr_serial_register_status vr_status_checker #(.CODE_W(CODE_W)) chk (.clk_sys_in, .rst_in,
    .cmd_valid_in, .cmd_code_in, .cmd_index_in, .temp_zone_in, .cmd_data_in, .modulator_ps_in,
    .output_in_window_in, .overcurrent_in, .secondary_status_changed_in, .modulator_ps_wr_in,
    .ack_valid_out, .alert_n_out, .ack_code_out, .rd_data_out, .output_code_target_out,
    .multi_reg_config_out, .power_state_out);
`default_nettype wire

// ---- sim/vr_bus_master.sv ----
// processor-side command master model
// assumes one-cycle command strobes answered by a one-cycle acknowledge
`timescale 1ns/1ps
`default_nettype none
module vr_bus_master (
    input  wire logic       clk_sys_in,    // system clock
    input  wire logic       ack_valid_in,  // answer strobe
    input  wire logic [1:0] ack_code_in,   // answer code
    input  wire logic [7:0] rd_data_in,    // read data
    output var  logic       cmd_valid_out, // command strobe
    output var  logic [2:0] cmd_code_out,  // command
    output var  logic [7:0] cmd_index_out, // index
    output var  logic [7:0] cmd_data_out   // payload
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 3'h0;
        cmd_index_out = 8'h00;
        cmd_data_out = 8'h00;
    end
    task automatic xfer(input logic [2:0] c, input logic [7:0] i, input logic [7:0] d,
                        output logic [1:0] ak, output logic [7:0] rd, output bit late);
        int n;
        @(posedge clk_sys_in);
        cmd_valid_out <= 1'b1;
        cmd_code_out <= c;
        cmd_index_out <= i;
        cmd_data_out <= d;
        @(posedge clk_sys_in);
        cmd_valid_out <= 1'b0;
        // released lines carry the inverse so stale-value reliance shows
        cmd_index_out <= ~i;
        cmd_data_out <= ~d;
        n = 0;
        #1;
        while (ack_valid_in !== 1'b1 && n < 4) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        late = (ack_valid_in !== 1'b1);
        ak = ack_code_in;
        rd = rd_data_in;
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the register file and primary status register
// assumes the master model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "vr_serial_register_status_map.vh"
module tb_top;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, win = 1'b0, oc = 1'b0, sec = 1'b0, mwr = 1'b0;
    logic [7:0] temp = 8'h00, mps = 8'h00, idx, dat, rdd, tgt, cfg, pst, rd;
    logic [2:0] code;
    logic [1:0] akc;
    logic vld, akv, alert_n;
    int failures = 0, total_checks = 0;
    initial forever #2 clk_sys_in = ~clk_sys_in;
    vr_bus_master master (.clk_sys_in, .ack_valid_in(akv), .ack_code_in(akc), .rd_data_in(rdd),
        .cmd_valid_out(vld), .cmd_code_out(code), .cmd_index_out(idx), .cmd_data_out(dat));
    vr_serial_register_status uut (.clk_sys_in, .rst_in, .cmd_valid_in(vld), .cmd_code_in(code),
        .cmd_index_in(idx), .cmd_data_in(dat), .output_in_window_in(win), .temp_zone_in(temp),
        .overcurrent_in(oc), .secondary_status_changed_in(sec), .modulator_ps_wr_in(mwr),
        .modulator_ps_in(mps), .ack_valid_out(akv), .ack_code_out(akc), .rd_data_out(rdd),
        .output_code_target_out(tgt), .multi_reg_config_out(cfg), .power_state_out(pst),
        .alert_n_out(alert_n));
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cmd(input logic [2:0] c, input logic [7:0] i, input logic [7:0] d, input logic [1:0] ea);
        logic [1:0] ak;
        bit late;
        master.xfer(c, i, d, ak, rd, late);
        if (late) begin
            failures++;
            final_report();
        end
        chk({6'h00, ak}, {6'h00, ea});
    endtask
    task rdc(input logic [7:0] i, input logic [7:0] e);
        cmd(`CMD_READ_REGISTER, i, 8'h00, `ACK_OK);
        chk(rd, e);
    endtask
    task t_registers;
        rdc(`IDX_MAX_OUTPUT_CODE, `RST_MAX_OUTPUT_CODE);
        for (int k = 8'h31; k <= 8'h35; k++) rdc(k[7:0], `RST_ZERO);
        cmd(`CMD_READ_REGISTER, 8'h2a, 8'h00, `ACK_REJECT);
        chk(rd, 8'h00);
        cmd(`CMD_WRITE_REGISTER, 8'h6f, 8'h11, `ACK_REJECT);
        for (int k = 8'h30; k <= 8'h35; k++)
            cmd(`CMD_WRITE_REGISTER, k[7:0], k[7:0] ^ 8'h5a, `ACK_OK);
        for (int k = 8'h30; k <= 8'h35; k++) rdc(k[7:0], k[7:0] ^ 8'h5a);
        cmd(`CMD_WRITE_REGISTER, `IDX_MAX_OUTPUT_CODE, 8'h80, `ACK_OK);
        cmd(`CMD_SET_OUTPUT_CODE, 8'h00, 8'h81, `ACK_NOT_SUPPORTED);
        rdc(`IDX_OUTPUT_CODE_SETTING, 8'h6b);
        cmd(`CMD_SET_OUTPUT_CODE, 8'h00, 8'h80, `ACK_OK);
        rdc(`IDX_OUTPUT_CODE_SETTING, 8'h80);
        cmd(`CMD_WRITE_REGISTER, `IDX_OUTPUT_CODE_OFFSET, 8'hff, `ACK_OK);
        @(posedge clk_sys_in);
        @(negedge clk_sys_in) chk(tgt, 8'h7f);
        cmd(`CMD_SET_INDEX, 8'h00, `IDX_MULTI_REG_CONFIG, `ACK_OK);
        cmd(`CMD_WRITE_INDEXED, 8'h00, 8'ha5, `ACK_OK);
        chk(cfg, 8'ha5);
        rdc(`IDX_INDIRECT_SCRATCH, `IDX_MULTI_REG_CONFIG);
        @(posedge clk_sys_in) mwr <= 1'b1;
        mps <= 8'h3c;
        @(posedge clk_sys_in) mwr <= 1'b0;
        rdc(`IDX_POWER_STATE, 8'h3c);
        chk(pst, 8'h3c);
    endtask
    task t_status;
        rdc(`IDX_PRIMARY_STATUS, 8'h00);
        @(posedge clk_sys_in) win <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        chk({7'h00, alert_n}, 8'h00);
        rdc(`IDX_PRIMARY_STATUS, 8'h01);
        chk({7'h00, alert_n}, 8'h01);
        @(posedge clk_sys_in) oc <= 1'b1;
        @(posedge clk_sys_in) oc <= 1'b0;
        rdc(`IDX_PRIMARY_STATUS, 8'h05);
        rdc(`IDX_PRIMARY_STATUS, 8'h01);
        @(posedge clk_sys_in) temp <= 8'h40;
        repeat (3) @(posedge clk_sys_in);
        chk({7'h00, alert_n}, 8'h00);
        rdc(`IDX_PRIMARY_STATUS, 8'h03);
        rdc(`IDX_PRIMARY_STATUS, 8'h03);
        @(posedge clk_sys_in) sec <= 1'b1;
        rdc(`IDX_PRIMARY_STATUS, 8'h83);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_registers();
        t_status();
        final_report();
    end
endmodule
`default_nettype wire
